/* rtl/mids_decode_stack.v */
// Notes on behaviour
// - Only fixed 16-bit instruction words are decoded.
// - Bit 15 picks immediate or register source.
// - Bits 7:0 are source; low nibble module, high nibble index.
// - Bits 14:8 are destination; low four module, upper three subindex.
// - Upper 24 destinations need a prefix write costing one cycle.
// - Each instruction executes in one cycle except returns, which add a PC reload cycle.
// - Certain register moves trigger side effects like stack operations.
// - Three data pointers auto-increment or auto-decrement after access.
// - Sixteen accumulators; operations use the active accumulator.
// - Stack holds 16 entries of 16 bits.
// - Stack used by call, return, interrupts, push, pop variants.
// - Reset loads stack pointer with 0Fh.
// - Call, push, interrupt: increment pointer, then store.
// - Return, pops: read current entry, then decrement.
// - After reset the program counter starts at 8000h.
`timescale 1ns/100ps
`default_nettype none
`include "mids_consts.vh"
module mids_decode_stack #(
    parameter DP_STEP_W = 16
) (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    input  wire [15:0] insn_in,
    input  wire        insn_valid_in,
    input  wire [15:0] src_data_in,
    input  wire        irq_take_in,
    input  wire [15:0] irq_vector_in,
    output reg  [15:0] pc_out,
    output reg         src_is_imm_out,
    output reg  [7:0]  src_imm_out,
    output reg  [3:0]  src_mod_out,
    output reg  [3:0]  src_idx_out,
    output reg  [3:0]  dst_mod_out,
    output reg  [4:0]  dst_idx_out,
    output reg         dst_wr_out,
    output reg  [15:0] move_data_out,
    output reg  [3:0]  stack_pointer_out,
    output reg  [15:0] stack_top_out,
    output reg  [3:0]  acc_sel_out,
    output reg  [15:0] dp0_out,
    output reg  [15:0] dp1_out,
    output reg  [15:0] dp2_out,
    output reg         irq_active_out
);
    localparam ST_RUN = 2'b01;
    localparam ST_RET = 2'b10;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [15:0] pc_q;
    reg  [3:0]  stack_pointer_q;
    reg  [1:0]  destination_prefix_register_q;
    reg         pfx_valid_q;
    reg         ret_irq_q;
    reg  [3:0]  acc_sel_q;
    reg  [15:0] dp_q [0:2];
    wire [15:0] stack_rd;

    // Field split of the single instruction word
    wire       fmt      = insn_in[`MIDS_FMT_BIT];
    wire [7:0] src_fld  = insn_in[7:0];
    wire [3:0] s_mod    = src_fld[3:0];
    wire [3:0] s_idx    = src_fld[7:4];
    wire [3:0] d_mod    = insn_in[11:8];
    wire [2:0] d_sub    = insn_in[14:12];
    wire [15:0] src_val = fmt ? src_data_in : {8'h00, src_fld};
    // Prefix bits widen the 3-bit subindex to reach the upper 24
    wire [4:0] d_idx    = pfx_valid_q ?
                          {destination_prefix_register_q, d_sub} :
                          {2'b00, d_sub};
    wire pfx_wr  = d_mod == `MIDS_PFX_MOD;
    wire stk_op  = d_mod == `MIDS_STK_MOD && !pfx_wr;
    wire run     = state_q == ST_RUN && insn_valid_in;
    wire do_push = run && stk_op &&
                   (d_sub == `MIDS_SUB_PUSH || d_sub == `MIDS_SUB_CALL);
    wire do_pop  = run && stk_op && (d_sub == `MIDS_SUB_POP ||
                   d_sub == `MIDS_SUB_POP_INTERRUPT_VARIANT || d_sub == `MIDS_SUB_RET ||
                   d_sub == `MIDS_SUB_RETURN_FROM_INTERRUPT);
    wire do_irq  = state_q == ST_RUN && irq_take_in;
    wire [3:0] sp_inc = stack_pointer_q + 4'h1;
    wire [3:0] sp_dec = stack_pointer_q - 4'h1;
    wire [15:0] pc_next = pc_q + 16'h0001;
    wire [15:0] push_val = do_irq ? pc_q :
                           (d_sub == `MIDS_SUB_CALL ? pc_next : src_val);
    wire        wr_stk  = do_irq || do_push;

    mids_stack_mem #(
        .DEPTH (`MIDS_STACK_DEPTH),
        .AW    (`MIDS_SP_W),
        .DW    (`MIDS_INSN_W)
    ) u_stack (
        .ref_clk_in  (ref_clk_in),
        .wr_en_in    (wr_stk),
        .wr_addr_in  (sp_inc),
        .wr_data_in  (push_val),
        .rd_addr_in  (wr_stk ? sp_inc : stack_pointer_q),
        .rd_data_out (stack_rd)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (!do_irq && do_pop &&
                    (d_sub == `MIDS_SUB_RET || d_sub == `MIDS_SUB_RETURN_FROM_INTERRUPT)) begin
                    state_d = ST_RET;
                end
            end
            ST_RET:  state_d = ST_RUN;
            default: state_d = ST_RUN;
        endcase
    end

    integer i;
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q                       <= ST_RUN;
            pc_q                          <= `MIDS_PC_RESET;
            stack_pointer_q               <= `MIDS_SP_RESET;
            destination_prefix_register_q <= 2'b00;
            pfx_valid_q                   <= 1'b0;
            ret_irq_q                     <= 1'b0;
            acc_sel_q                     <= 4'h0;
            for (i = 0; i < `MIDS_DP_COUNT; i = i + 1) begin
                dp_q[i] <= 16'h0000;
            end
            irq_active_out                <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_RET) begin
                // Popped word available one cycle after the read
                pc_q <= stack_rd;
                if (ret_irq_q) begin
                    irq_active_out <= 1'b0;
                end
            end else if (do_irq) begin
                stack_pointer_q <= sp_inc;
                pc_q            <= irq_vector_in;
                irq_active_out  <= 1'b1;
            end else if (run) begin
                pc_q <= pc_next;
                // Prefix holds for exactly the next instruction
                pfx_valid_q <= pfx_wr;
                if (pfx_wr) begin
                    destination_prefix_register_q <= src_val[1:0];
                end
                if (do_push) begin
                    stack_pointer_q <= sp_inc;
                    if (d_sub == `MIDS_SUB_CALL) begin
                        pc_q <= src_val;
                    end
                end
                if (do_pop) begin
                    stack_pointer_q <= sp_dec;
                    ret_irq_q <= d_sub == `MIDS_SUB_RETURN_FROM_INTERRUPT;
                    if (d_sub == `MIDS_SUB_POP_INTERRUPT_VARIANT) begin
                        irq_active_out <= 1'b0;
                    end
                end
                if (d_mod == `MIDS_AP_MOD && d_sub == 3'h0) begin
                    acc_sel_q <= src_val[3:0];
                end
                for (i = 0; i < `MIDS_DP_COUNT; i = i + 1) begin
                    if (d_mod == `MIDS_DP_MOD && d_sub == i) begin
                        dp_q[i] <= src_val;
                    end else if (fmt && s_mod == `MIDS_DP_MOD &&
                                 s_idx[2:0] == i) begin
                        // Post-access step: index bit 3 selects decrement
                        dp_q[i] <= s_idx[3] ? dp_q[i] - 16'h0001
                                            : dp_q[i] + 16'h0001;
                    end
                end
            end
        end
    end

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pc_out            <= `MIDS_PC_RESET;
            src_is_imm_out    <= 1'b0;
            src_imm_out       <= 8'h00;
            src_mod_out       <= 4'h0;
            src_idx_out       <= 4'h0;
            dst_mod_out       <= 4'h0;
            dst_idx_out       <= 5'h00;
            dst_wr_out        <= 1'b0;
            move_data_out     <= 16'h0000;
            stack_pointer_out <= `MIDS_SP_RESET;
            stack_top_out     <= 16'h0000;
            acc_sel_out       <= 4'h0;
            dp0_out           <= 16'h0000;
            dp1_out           <= 16'h0000;
            dp2_out           <= 16'h0000;
        end else begin
            pc_out            <= pc_q;
            src_is_imm_out    <= !fmt;
            src_imm_out       <= src_fld;
            src_mod_out       <= s_mod;
            src_idx_out       <= s_idx;
            dst_mod_out       <= d_mod;
            dst_idx_out       <= d_idx;
            // Side-effect moves do not reach the ordinary register file
            dst_wr_out        <= run && !do_irq && !pfx_wr && !stk_op;
            move_data_out     <= do_pop ? stack_rd : src_val;
            stack_pointer_out <= stack_pointer_q;
            stack_top_out     <= stack_rd;
            acc_sel_out       <= acc_sel_q;
            dp0_out           <= dp_q[0];
            dp1_out           <= dp_q[1];
            dp2_out           <= dp_q[2];
        end
    end
endmodule
`default_nettype wire

/* inc/mids_consts.vh */
`ifndef MIDS_CONSTS_VH
`define MIDS_CONSTS_VH
`define MIDS_INSN_W        16
`define MIDS_FMT_BIT       15
`define MIDS_SRC_MOD_LSB   0
`define MIDS_SRC_IDX_LSB   4
`define MIDS_DST_MOD_LSB   8
`define MIDS_DST_SUB_LSB   12
`define MIDS_DST_SUB_MSB   14
`define MIDS_SP_RESET      4'hf
`define MIDS_PC_RESET      16'h8000
`define MIDS_STACK_DEPTH   16
`define MIDS_SP_W          4
`define MIDS_PFX_W         2
`define MIDS_ACC_COUNT     16
`define MIDS_DP_COUNT      3
`define MIDS_PFX_MOD       4'hb
`define MIDS_DP_MOD        4'h3
`define MIDS_ACC_MOD       4'h8
`define MIDS_AP_MOD        4'h8
`define MIDS_STK_MOD       4'hd
`define MIDS_SUB_PUSH      3'h0
`define MIDS_SUB_POP       3'h1
`define MIDS_SUB_POP_INTERRUPT_VARIANT      3'h2
`define MIDS_SUB_CALL      3'h3
`define MIDS_SUB_RET       3'h4
`define MIDS_SUB_RETURN_FROM_INTERRUPT      3'h5
`endif

/* rtl/mids_stack_mem.v */
`timescale 1ns/100ps
`default_nettype none
module mids_stack_mem #(
    parameter DEPTH = 16,
    parameter AW    = 4,
    parameter DW    = 16
) (
    input  wire          ref_clk_in,
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [DW-1:0] wr_data_in,
    input  wire [AW-1:0] rd_addr_in,
    output reg  [DW-1:0] rd_data_out
);
    reg [DW-1:0] mem [0:DEPTH-1];

    // Registered read; write-through so a same-cycle write is seen
    always @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        if (wr_en_in && wr_addr_in == rd_addr_in) begin
            rd_data_out <= wr_data_in;
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule
`default_nettype wire

/* bench/mids_decode_stack_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module mids_decode_stack_checker (
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic [15:0] insn_in,
    input wire logic        insn_valid_in,
    input wire logic        irq_take_in,
    input wire logic [15:0] pc_out,
    input wire logic        src_is_imm_out,
    input wire logic [7:0]  src_imm_out,
    input wire logic [3:0]  src_mod_out,
    input wire logic [3:0]  src_idx_out,
    input wire logic [3:0]  dst_mod_out,
    input wire logic [4:0]  dst_idx_out,
    input wire logic        dst_wr_out,
    input wire logic [3:0]  stack_pointer_out,
    input wire logic [15:0] stack_top_out
);
    logic      ret_q;
    wire logic tk  = insn_valid_in && !irq_take_in && !ret_q;
    wire logic stk = insn_in[11:8] == 4'hd;
    wire logic ret = insn_in[14:12] == 3'h4 || insn_in[14:12] == 3'h5;
    // Word after a return is dropped while the PC reloads
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in)
            ret_q <= 1'b0;
        else
            ret_q <= tk && stk && ret;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence push_s; tk && stk && insn_in[14:12] == 3'h0; endsequence
    sequence pop_s;
        tk && stk && (insn_in[14:12] == 3'h1 || insn_in[14:12] == 3'h2);
    endsequence
    sequence pfx_s; tk && insn_in[11:8] == 4'hb && !insn_in[15]; endsequence
    reset_state_a: assert property (disable iff (1'b0)
        rst_in && $past(rst_in) |-> stack_pointer_out == 4'hf
        && pc_out == 16'h8000) else $error("bad reset state");
    src_format_a: assert property (tk |=>
        src_is_imm_out == !$past(insn_in[15])) else $error("bad format");
    src_field_a: assert property (tk |=> {src_idx_out, src_mod_out} ==
        $past(insn_in[7:0]) && src_imm_out == $past(insn_in[7:0]))
        else $error("bad source field");
    dst_field_a: assert property (tk |=> dst_mod_out == $past(insn_in[11:8])
        && dst_idx_out[2:0] == $past(insn_in[14:12])) else $error("bad dest");
    dst_write_a: assert property (tk && !stk && insn_in[11:8] != 4'hb
        |=> dst_wr_out) else $error("missing dest write");
    prefix_use_a: assert property (pfx_s ##1 tk |=>
        dst_idx_out[4:3] == $past(insn_in[1:0], 2)) else $error("bad prefix");
    // Pointer port trails the internal pointer by one edge
    push_incr_a: assert property (push_s |=> ##1
        stack_pointer_out == $past(stack_pointer_out) + 4'h1)
        else $error("push pointer wrong");
    pop_decr_a: assert property (pop_s |=> ##1
        stack_pointer_out == $past(stack_pointer_out) - 4'h1)
        else $error("pop pointer wrong");
    irq_push_a: assert property (irq_take_in && !ret_q |=>
        ##1 stack_pointer_out == $past(stack_pointer_out) + 4'h1)
        else $error("interrupt pointer wrong");
    stack_write_a: assert property (push_s and !insn_in[15] |=> ##1
        stack_top_out[7:0] == $past(insn_in[7:0], 2)) else $error("bad top");
endmodule
bind mids_decode_stack mids_decode_stack_checker mids_decode_stack_checker_inst (
    .ref_clk_in, .rst_in, .insn_in, .insn_valid_in, .irq_take_in, .pc_out,
    .src_is_imm_out, .src_imm_out, .src_mod_out, .src_idx_out, .dst_mod_out,
    .dst_idx_out, .dst_wr_out, .stack_pointer_out, .stack_top_out);
`default_nettype wire

/* bench/tb_mids_decode_stack.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_mids_decode_stack;
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [15:0] insn_in = 16'h0000;
    logic        insn_valid_in = 1'b0;
    logic        irq_take_in = 1'b0;
    logic [15:0] irq_vector_in = 16'h4000;
    logic [15:0] src_data_in = 16'h1234;
    logic [15:0] pc_out, move_data_out, stack_top_out, dp0_out, dp1_out, dp2_out;
    logic [7:0]  src_imm_out;
    logic [4:0]  dst_idx_out;
    logic [3:0]  src_mod_out, src_idx_out, dst_mod_out, stack_pointer_out;
    logic [3:0]  acc_sel_out;
    logic        src_is_imm_out, dst_wr_out, irq_active_out;
    int          err_total = 0;
    int          num_checks = 0;
    logic [33:0] rows [4] = '{
        {16'h0123, 1'b1, 4'h2, 4'h3, 5'h00, 4'h1},
        {16'hf4a7, 1'b0, 4'ha, 4'h7, 5'h07, 4'h4},
        {16'h8a5e, 1'b0, 4'h5, 4'he, 5'h00, 4'ha},
        {16'h7c0f, 1'b1, 4'h0, 4'hf, 5'h07, 4'hc}};
    mids_decode_stack mids_decode_stack_inst (.ref_clk_in, .rst_in, .insn_in,
        .insn_valid_in, .src_data_in, .irq_take_in, .irq_vector_in, .pc_out,
        .src_is_imm_out, .src_imm_out, .src_mod_out, .src_idx_out, .dst_mod_out,
        .dst_idx_out, .dst_wr_out, .move_data_out, .stack_pointer_out,
        .stack_top_out, .acc_sel_out, .dp0_out, .dp1_out, .dp2_out,
        .irq_active_out);
    initial forever #2 ref_clk_in = ~ref_clk_in;
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Valid stays up between words so back-to-back issue is real
    task run(input logic [15:0] w);
        insn_in = w;
        insn_valid_in = 1'b1;
        @(negedge ref_clk_in);
    endtask
    task halt;
        insn_valid_in = 1'b0;
        @(negedge ref_clk_in);
    endtask
    initial begin
        #4000;
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (5) @(negedge ref_clk_in);
        chk(stack_pointer_out, 4'hf);
        chk(pc_out, 16'h8000);
        rst_in = 1'b0;
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            run(rows[i][33:18]);
            chk({src_is_imm_out, src_idx_out, src_mod_out, dst_idx_out,
                 dst_mod_out}, rows[i][17:0]);
            chk(src_imm_out, rows[i][25:18]);
            chk(dst_wr_out, 1'b1);
            chk(move_data_out, rows[i][33] ? 16'h1234
                : {8'h00, rows[i][25:18]});
        end
        $display("decode test done");
        run(16'h0b03);
        chk(dst_wr_out, 1'b0);
        chk(move_data_out, 16'h0003);
        run(16'h5102);
        chk(dst_idx_out, 5'h1d);
        run(16'h5102);
        chk(dst_idx_out, 5'h05);
        run(16'h0805);
        // Selector port trails the internal select by one edge
        run(16'h0310);
        chk(acc_sel_out, 4'h5);
        halt;
        run(16'h8103);
        halt;
        chk(dp0_out, 16'h0011);
        run(16'h8183);
        halt;
        chk(dp0_out, 16'h0010);
        run(16'h1377);
        run(16'h2355);
        halt;
        chk(dp1_out, 16'h0077);
        chk(dp2_out, 16'h0055);
        $display("prefix and pointer test done");
        // Pointer port trails the pointer by one edge; top by one after a push, by two after a pop
        run(16'h0d5a);
        run(16'h0d3c);
        chk(stack_pointer_out, 4'h0);
        halt;
        chk(stack_pointer_out, 4'h1);
        chk(stack_top_out[7:0], 8'h3c);
        run(16'h1d00);
        chk(move_data_out, 16'h003c);
        halt;
        chk(stack_pointer_out, 4'h0);
        halt;
        chk(stack_top_out[7:0], 8'h5a);
        run(16'h2d00);
        run(16'h1d00);
        chk(stack_pointer_out, 4'hf);
        halt;
        chk(stack_pointer_out, 4'he);
        irq_take_in = 1'b1;
        @(negedge ref_clk_in);
        irq_take_in = 1'b0;
        chk(irq_active_out, 1'b1);
        run(16'h5d00);
        chk(stack_pointer_out, 4'hf);
        chk(pc_out, 16'h4000);
        halt;
        chk(stack_pointer_out, 4'he);
        chk(irq_active_out, 1'b0);
        halt;
        $display("stack test done");
        rst_in = 1'b1;
        @(negedge ref_clk_in);
        chk(stack_pointer_out, 4'hf);
        chk(pc_out, 16'h8000);
        $display("second reset test done");
        rst_in = 1'b0;
        run(16'h3d40);
        run(16'h4d00);
        chk(pc_out, 16'h0040);
        chk(move_data_out, 16'h8001);
        // A word offered in the reload cycle must be dropped
        run(16'h0d77);
        halt;
        chk(stack_pointer_out, 4'hf);
        chk(pc_out, 16'h8001);
        $display("call test done");
        end_of_test;
    end
endmodule
`default_nettype wire
